/* File: hw/pcrc_top.sv */
// Overview of operation
// - Terms from mask bits 15..1, length field.
// - x^0 and top x^(length) terms always applied.
// - Shifting only after start bit written one.
// - FIFO depth 8 if length>7, else 16.
// - Data window accepts byte-sized writes.
// - Word holds length field plus one bits.
// - Shift starts with start set and count nonzero; runs until count is zero.
// - Count decrements as each word's last bit (LSB) leaves.
// - One bit shifted per clock.
// - Full at depth, empty at zero.
// - Write while full rolls count to zero.
// - Interrupt when count goes one to zero.
// - Sleep freezes state, resumes afterwards.
// - Idle with stop bit suspends; no interrupts meanwhile.
// - Cleared start stops shifter once empty.
// - Count readable at control bits 12..8.
// - Length field is polynomial length minus one.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module pcrc_top #(
    parameter int DATA_W = pcrc_pkg::DATA_W
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_sys_rst,
    input  wire logic                         i_sleep,
    input  wire logic                         i_idle,
    input  wire logic [pcrc_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]            i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [DATA_W-1:0]            o_rdata,
    output logic                              o_irq
);
    pcrc_pkg::pcrc_bus_s bus;
    pcrc_pkg::pcrc_state_e state;

    logic [pcrc_pkg::LEN_W-1:0] poly_length_minus_one;
    logic [DATA_W-1:0]          polynomial_term_mask;
    logic                       shift_start_bit;
    logic                       stop_when_idle;
    logic [pcrc_pkg::CNT_W-1:0] fifo_word_count;
    logic [pcrc_pkg::LEN_W-1:0] bit_idx;
    logic [DATA_W-1:0]          shreg;
    logic [DATA_W-1:0]          fifo_out;
    logic [DATA_W-1:0]          crc_value;
    logic [pcrc_pkg::CNT_W-1:0] depth;
    logic                       fifo_full_flag;
    logic                       fifo_empty_flag;
    logic                       run_en;
    logic                       push;
    logic                       pop;
    logic                       rollover;
    logic                       step;
    logic                       msb_out;
    logic [DATA_W-1:0]          ctl_view;

    assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    // Sleep, or idle with the stop bit, freezes the shifter, count and FIFO; register writes still land.
    assign run_en = !i_sleep && !(i_idle && stop_when_idle);

    assign depth = (poly_length_minus_one > pcrc_pkg::DEEP_LEN_MAX)
                 ? pcrc_pkg::CNT_W'(pcrc_pkg::DEPTH_MIN)
                 : pcrc_pkg::CNT_W'(pcrc_pkg::DEPTH_MAX);
    assign fifo_full_flag = (fifo_word_count == depth);
    assign fifo_empty_flag = (fifo_word_count == '0);

    // A write to the data window, byte or word, holds one element unless suspended or the FIFO is full.
    assign push = run_en && bus.wr && (bus.addr == pcrc_pkg::ADDR_WINDOW);
    assign rollover = push && fifo_full_flag;
    assign step = run_en && (state == pcrc_pkg::PCRC_SHIFT);
    assign msb_out = step && (bit_idx == '0);
    // The next word loads as the last bit of the previous one leaves, so no cycle is lost.
    assign pop = (run_en && (state == pcrc_pkg::PCRC_LOAD))
              || (msb_out && (fifo_word_count > pcrc_pkg::CNT_W'(1)));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            poly_length_minus_one <= '0;
            shift_start_bit <= 1'b0;
            stop_when_idle <= 1'b0;
        end else if (bus.wr && bus.addr == pcrc_pkg::ADDR_CONTROL) begin
            poly_length_minus_one <= bus.wdata[pcrc_pkg::CTL_LEN_LSB +: pcrc_pkg::LEN_W];
            shift_start_bit <= bus.wdata[pcrc_pkg::CTL_START];
            stop_when_idle <= bus.wdata[pcrc_pkg::CTL_IDLE_STOP];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            polynomial_term_mask <= '0;
        end else if (bus.wr && bus.addr == pcrc_pkg::ADDR_TERMS) begin
            polynomial_term_mask <= bus.wdata & pcrc_pkg::TERMS_RW_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fifo_word_count <= '0;
        end else if (rollover) begin
            fifo_word_count <= '0;
        end else if (push && !msb_out) begin
            fifo_word_count <= fifo_word_count + 1'b1;
        end else if (!push && msb_out) begin
            fifo_word_count <= fifo_word_count - 1'b1;
        end
    end

    // Shifter: load a word, then send length+1 bits, MSB first.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || rollover) begin
            state <= pcrc_pkg::PCRC_IDLE;
        end else if (run_en) begin
            case (state)
                pcrc_pkg::PCRC_IDLE: begin
                    if (shift_start_bit && !fifo_empty_flag) begin
                        state <= pcrc_pkg::PCRC_LOAD;
                    end
                end
                pcrc_pkg::PCRC_LOAD: begin
                    state <= pcrc_pkg::PCRC_SHIFT;
                end
                pcrc_pkg::PCRC_SHIFT: begin
                    if (bit_idx == '0) begin
                        if (fifo_word_count > pcrc_pkg::CNT_W'(1)) begin
                            state <= pcrc_pkg::PCRC_SHIFT;
                        end else begin
                            state <= pcrc_pkg::PCRC_IDLE;
                        end
                    end
                end
                default: begin
                    state <= pcrc_pkg::PCRC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            shreg <= '0;
            bit_idx <= '0;
        end else if (pop) begin
            shreg <= fifo_out;
            bit_idx <= poly_length_minus_one;
        end else if (step) begin
            shreg <= shreg << 1;
            bit_idx <= bit_idx - 1'b1;
        end
    end

    pcrc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (pcrc_pkg::DEPTH_MAX)
    ) u_fifo (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_flush   (rollover),
        .i_push    (push && !rollover),
        .i_data    (bus.wdata),
        .i_pop     (pop),
        .o_data    (fifo_out)
    );

    pcrc_engine #(
        .WIDTH (DATA_W)
    ) u_engine (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_step    (step),
        .i_bit     (shreg[poly_length_minus_one]),
        .i_len_m1  (poly_length_minus_one),
        .i_terms   (polynomial_term_mask),
        .o_crc     (crc_value)
    );

    // Interrupt pulse on the one-to-zero move; none raised while suspended.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= msb_out && !push && (fifo_word_count == pcrc_pkg::CNT_W'(1));
        end
    end

    always_comb begin
        ctl_view = '0;
        ctl_view[pcrc_pkg::CTL_LEN_LSB +: pcrc_pkg::LEN_W] = poly_length_minus_one;
        ctl_view[pcrc_pkg::CTL_START] = shift_start_bit;
        ctl_view[pcrc_pkg::CTL_EMPTY] = fifo_empty_flag;
        ctl_view[pcrc_pkg::CTL_FULL] = fifo_full_flag;
        ctl_view[pcrc_pkg::CTL_CNT_LSB +: pcrc_pkg::CNT_W] = fifo_word_count;
        ctl_view[pcrc_pkg::CTL_IDLE_STOP] = stop_when_idle;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                pcrc_pkg::ADDR_CONTROL: o_rdata <= ctl_view;
                pcrc_pkg::ADDR_TERMS:   o_rdata <= polynomial_term_mask;
                pcrc_pkg::ADDR_WINDOW:  o_rdata <= crc_value;
                default:                o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end
endmodule : pcrc_top

/* File: hw/pcrc_pkg.sv */
package pcrc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 5;
    localparam int LEN_W = 4;
    localparam int DEPTH_MAX = 16;
    localparam int DEPTH_MIN = 8;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_TERMS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_WINDOW = 4'h8;

    localparam int CTL_LEN_LSB = 0;
    localparam int CTL_START = 4;
    localparam int CTL_EMPTY = 6;
    localparam int CTL_FULL = 7;
    localparam int CTL_CNT_LSB = 8;
    localparam int CTL_IDLE_STOP = 13;

    localparam logic [LEN_W-1:0] DEEP_LEN_MAX = 4'h7;
    localparam logic [DATA_W-1:0] TERMS_RW_MASK = 16'hfffe;

    typedef enum logic [1:0] {
        PCRC_IDLE,
        PCRC_LOAD,
        PCRC_SHIFT
    } pcrc_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pcrc_bus_s;
endpackage : pcrc_pkg

/* File: hw/pcrc_fifo.sv */
`timescale 1ns/100ps
module pcrc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_flush,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_flush) begin
            wr_ptr <= '0;
        end else if (i_push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_flush) begin
            rd_ptr <= '0;
        end else if (i_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    assign o_data = mem[rd_ptr];
endmodule : pcrc_fifo

/* File: hw/pcrc_engine.sv */
`timescale 1ns/100ps
module pcrc_engine #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_step,
    input  wire logic             i_bit,
    input  wire logic [3:0]       i_len_m1,
    input  wire logic [WIDTH-1:0] i_terms,
    output logic      [WIDTH-1:0] o_crc
);
    logic [WIDTH-1:0] crc;
    logic [WIDTH-1:0] next_crc;
    logic             fb;

    // Feedback taken from the top stage of the programmed length.
    always_comb begin
        fb = crc[i_len_m1] ^ i_bit;
        next_crc = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (i == 0) begin
                next_crc[i] = fb;
            end else if (i <= int'(i_len_m1)) begin
                next_crc[i] = crc[i-1] ^ (fb & i_terms[i]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            crc <= '0;
        end else if (i_step) begin
            crc <= next_crc;
        end
    end

    assign o_crc = crc;
endmodule : pcrc_engine

/* File: tb/pcrc_checker.sv */
`timescale 1ns/100ps
module pcrc_checker #(
    parameter int DATA_W = 16
) (
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_sleep,
    input wire logic              i_idle,
    input wire logic [3:0]        i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_ctl_rd;
        i_rd && i_addr == pcrc_pkg::ADDR_CONTROL;
    endsequence

    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside a read slot");
    a_irq_pulse: assert property (o_irq |=> !o_irq)
        else $error("interrupt longer than one cycle");
    a_reset_quiet: assert property ($past(i_sys_rst) |-> !o_irq && o_rdata == '0)
        else $error("outputs active after reset");
    a_unmapped_zero: assert property (i_rd && !(i_addr inside {4'h0, 4'h4, 4'h8})
        |=> o_rdata == '0)
        else $error("unmapped read not zero");
    a_terms_bit0: assert property (i_rd && i_addr == pcrc_pkg::ADDR_TERMS
        |=> !o_rdata[0])
        else $error("term mask bit zero set");
    a_ctl_unused: assert property (s_ctl_rd |=> o_rdata[15:14] == 2'h0 && !o_rdata[5])
        else $error("unused control bits set");
    a_empty_flag: assert property (s_ctl_rd |=> o_rdata[6] == (o_rdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    a_full_flag: assert property (s_ctl_rd |=> o_rdata[7] == (o_rdata[12:8] == 5'h10
        || (o_rdata[12:8] == 5'h08 && o_rdata[3])))
        else $error("full flag disagrees with count");
    a_count_max: assert property (s_ctl_rd |=> o_rdata[12:8] <= 5'h10)
        else $error("count above depth");
    a_sleep_no_irq: assert property (i_sleep |=> !o_irq)
        else $error("interrupt raised while asleep");

    cover property (o_irq);
    cover property (s_ctl_rd ##1 o_rdata[7]);
    cover property (i_sleep [*8]);
endmodule : pcrc_checker

bind pcrc_top pcrc_checker #(.DATA_W(DATA_W)) i_pcrc_checker (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sleep(i_sleep), .i_idle(i_idle),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq));

/* File: tb/test_programmable_crc_generator.sv */
`timescale 1ns/100ps
module test_programmable_crc_generator;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_sleep = 1'b0;
    logic        i_idle = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic        o_irq;
    logic [15:0] crc = 16'h0000;
    logic [15:0] v;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          irqs = 0;
    int          n;

    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_irq === 1'b1) irqs <= irqs + 1;

    pcrc_top i_pcrc_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sleep(i_sleep),
        .i_idle(i_idle), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq));

    task results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task rchk(input logic [3:0] a, input logic [15:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
        @(posedge i_clk);
    endtask : rchk

    task wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_irq !== 1'b1 && n < lim);
        if (o_irq !== 1'b1) begin
            num_errors++;
            results();
        end
    endtask : wait_irq

    function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [15:0] d,
                                            input logic [15:0] t, input int l);
        logic        fb;
        logic [15:0] m;
        m = 16'hffff >> (15 - l);
        for (int i = l; i >= 0; i--) begin
            fb = c[l] ^ d[i];
            c = (c << 1) & m;
            if (fb) c = c ^ ((t | 16'h0001) & m);
        end
        return c;
    endfunction : crc_ref

    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h0040);
        rchk(pcrc_pkg::ADDR_WINDOW, 16'h0000);
        rchk(4'hc, 16'h0000);
        wr(pcrc_pkg::ADDR_TERMS, 16'hffff);
        rchk(pcrc_pkg::ADDR_TERMS, 16'hfffe);
        wr(pcrc_pkg::ADDR_TERMS, 16'h1020);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h000f);
        wr(pcrc_pkg::ADDR_WINDOW, 16'h1234);
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h010f);
        wr(pcrc_pkg::ADDR_WINDOW, 16'habcd);
        repeat (40) @(posedge i_clk);
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h020f);
        crc = crc_ref(crc_ref(crc, 16'h1234, 16'h1020, 15), 16'habcd, 16'h1020, 15);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h001f);
        wait_irq(60);
        chk(16'(n >= 31 && n <= 38), 16'h0001);
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h005f);
        rchk(pcrc_pkg::ADDR_WINDOW, crc);
        chk(16'(irqs), 16'h0001);
        for (int m = 0; m < 3; m++) begin
            wr(pcrc_pkg::ADDR_CONTROL, (m == 1) ? 16'h201f : 16'h001f);
            wr(pcrc_pkg::ADDR_WINDOW, 16'h5a5a + 16'(m));
            i_sleep <= (m == 0);
            i_idle <= (m != 0);
            crc = crc_ref(crc, 16'h5a5a + 16'(m), 16'h1020, 15);
            if (m < 2) begin
                repeat (60) @(posedge i_clk);
                rchk(pcrc_pkg::ADDR_CONTROL, (m == 1) ? 16'h211f : 16'h011f);
                i_sleep <= 1'b0;
                i_idle <= 1'b0;
            end
            wait_irq(40);
            rchk(pcrc_pkg::ADDR_WINDOW, crc);
        end
        i_idle <= 1'b0;
        for (int l = 7; l < 9; l++) begin
            wr(pcrc_pkg::ADDR_CONTROL, 16'(l));
            for (int i = 0; i < ((l > 7) ? 8 : 16); i++)
                wr(pcrc_pkg::ADDR_WINDOW, 16'(i));
            rchk(pcrc_pkg::ADDR_CONTROL, 16'(((l > 7) ? 8 : 16) << 8) | 16'h0080 | 16'(l));
            wr(pcrc_pkg::ADDR_WINDOW, 16'h00ff);
            rchk(pcrc_pkg::ADDR_CONTROL, 16'h0040 | 16'(l));
        end
        chk(16'(irqs), 16'h0004);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0017);
        wr(pcrc_pkg::ADDR_WINDOW, 16'h12a5);
        wr(pcrc_pkg::ADDR_WINDOW, 16'h0033);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0007);
        crc = crc_ref(crc_ref(crc, 16'h12a5, 16'h1020, 7), 16'h0033, 16'h1020, 7);
        wait_irq(40);
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h0047);
        rchk(pcrc_pkg::ADDR_WINDOW, crc);
        chk(16'(irqs), 16'h0005);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rchk(pcrc_pkg::ADDR_CONTROL, 16'h0040);
        rchk(pcrc_pkg::ADDR_TERMS, 16'h0000);
        rchk(pcrc_pkg::ADDR_WINDOW, 16'h0000);
        results();
    end
endmodule : test_programmable_crc_generator
